// file: position_error_clear_and_gear.sv
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module position_error_clear_and_gear
  import gear_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // pins from the host controller, active low
  input wire logic i_error_clear_input_n,
  input wire logic i_gear_select_input_n,
  // decoded reference and feedback counts
  input wire logic i_ref_pulse,
  input wire logic i_ref_dir,
  input wire logic i_fb_pulse,
  input wire logic i_fb_dir,
  // drive state
  input wire logic i_servo_on,
  input wire logic i_overtravel,
  input wire logic i_zero_clamp,
  // results
  output logic signed [ERR_W-1:0] o_err_count,
  output logic o_loop_en,
  output logic o_gear_two
);

  // ==========================================================
  // declarations
  logic [1:0] clr_sync_q;
  logic [1:0] sel_sync_q;
  logic [GEAR_W-1:0] num_one_sh_q;
  logic [GEAR_W-1:0] num_one_sh_d;
  logic [GEAR_W-1:0] den_sh_q;
  logic [GEAR_W-1:0] den_sh_d;
  logic [GEAR_W-1:0] num_two_sh_q;
  logic [GEAR_W-1:0] num_two_sh_d;
  logic [1:0] mode_sh_q;
  logic [1:0] mode_sh_d;
  logic sw_en_sh_q;
  logic sw_en_sh_d;
  logic sw_seq_sh_q;
  logic sw_seq_sh_d;
  logic [GEAR_W-1:0] num_one_q;
  logic [GEAR_W-1:0] num_one_d;
  logic [GEAR_W-1:0] den_q;
  logic [GEAR_W-1:0] den_d;
  logic [GEAR_W-1:0] num_two_q;
  logic [GEAR_W-1:0] num_two_d;
  clear_mode_t mode_q;
  clear_mode_t mode_d;
  logic sw_en_q;
  logic sw_en_d;
  logic sw_seq_q;
  logic sw_seq_d;
  logic gear_two_q;
  logic gear_two_d;
  logic signed [ERR_W-1:0] err_q;
  logic signed [ERR_W-1:0] err_d;
  logic loop_en_q;
  logic loop_en_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic restart;
  logic pin_clear;
  logic auto_clear;
  logic want_two;
  logic signed [ERR_W-1:0] fb_step;

  // scaler link: residue, drain and idle state live in the child
  gear_if g ();

  gear_scaler u_scaler (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .g(g.scaler)
  );

  // out-of-range settings are pulled into range so a zero divisor can never stall
  function automatic logic [GEAR_W-1:0] gear_limit(input logic [GEAR_W-1:0] v);
    logic [GEAR_W-1:0] r;
    r = v;
    if (v < GEAR_MIN) begin
      r = GEAR_MIN;
    end else if (v > GEAR_MAX) begin
      r = GEAR_MAX;
    end
    return r;
  endfunction

  // ==========================================================
  // pin synchronisers
  // both stages reset to the idle high level so leaving reset never looks like a clear
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      clr_sync_q <= 2'h3;
      sel_sync_q <= 2'h3;
    end else begin
      clr_sync_q <= {clr_sync_q[0], i_error_clear_input_n};
      sel_sync_q <= {sel_sync_q[0], i_gear_select_input_n};
    end
  end

  assign pin_clear = !clr_sync_q[1];

  // ==========================================================
  // staged settings written by software
  always_comb begin
    num_one_sh_d = num_one_sh_q;
    den_sh_d = den_sh_q;
    num_two_sh_d = num_two_sh_q;
    mode_sh_d = mode_sh_q;
    sw_en_sh_d = sw_en_sh_q;
    sw_seq_sh_d = sw_seq_sh_q;
    restart = 1'b0;
    // restart is a one-cycle strobe and is never stored
    if (i_wr) begin
      unique case (i_addr)
        OFS_NUM_ONE: begin
          num_one_sh_d = i_wdata[GEAR_W-1:0];
        end
        OFS_DEN: begin
          den_sh_d = i_wdata[GEAR_W-1:0];
        end
        OFS_NUM_TWO: begin
          num_two_sh_d = i_wdata[GEAR_W-1:0];
        end
        OFS_CFG: begin
          mode_sh_d = i_wdata[CFG_MODE_MSB:CFG_MODE_LSB];
          sw_en_sh_d = i_wdata[CFG_SW_EN];
          sw_seq_sh_d = i_wdata[CFG_SW_SEQ];
        end
        OFS_CTRL: begin
          restart = i_wdata[CTRL_RESTART];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      num_one_sh_q <= GEAR_DEFAULT;
      den_sh_q <= GEAR_DEFAULT;
      num_two_sh_q <= GEAR_DEFAULT;
      mode_sh_q <= MODE_DEFAULT;
      sw_en_sh_q <= 1'b0;
      sw_seq_sh_q <= 1'b0;
    end else begin
      num_one_sh_q <= num_one_sh_d;
      den_sh_q <= den_sh_d;
      num_two_sh_q <= num_two_sh_d;
      mode_sh_q <= mode_sh_d;
      sw_en_sh_q <= sw_en_sh_d;
      sw_seq_sh_q <= sw_seq_sh_d;
    end
  end

  // ==========================================================
  // active settings, taken over only at restart
  // settings change only here so a half-written ratio never reaches the scaler
  always_comb begin
    num_one_d = num_one_q;
    den_d = den_q;
    num_two_d = num_two_q;
    mode_d = mode_q;
    sw_en_d = sw_en_q;
    sw_seq_d = sw_seq_q;
    if (restart) begin
      num_one_d = gear_limit(num_one_sh_q); // RULE12
      den_d = gear_limit(den_sh_q); // RULE12
      num_two_d = gear_limit(num_two_sh_q); // RULE12
      sw_en_d = sw_en_sh_q;
      sw_seq_d = sw_seq_sh_q;
      unique case (mode_sh_q)
        2'h0: mode_d = CLR_OFF_ONLY; // RULE4
        2'h2: mode_d = CLR_OFF_AND_OT;
        default: mode_d = CLR_NEVER;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      num_one_q <= GEAR_DEFAULT;
      den_q <= GEAR_DEFAULT;
      num_two_q <= GEAR_DEFAULT;
      mode_q <= CLR_OFF_ONLY;
      sw_en_q <= 1'b0;
      sw_seq_q <= 1'b0;
    end else begin
      num_one_q <= num_one_d;
      den_q <= den_d;
      num_two_q <= num_two_d;
      mode_q <= mode_d;
      sw_en_q <= sw_en_d;
      sw_seq_q <= sw_seq_d;
    end
  end

  // ==========================================================
  // clearing and gear selection
  always_comb begin
    // mode levels act every cycle, so servo off holds the count at zero, not just once
    auto_clear = 1'b0;
    unique case (mode_q)
      CLR_OFF_ONLY: auto_clear = !i_servo_on; // RULE4
      CLR_NEVER: auto_clear = 1'b0; // RULE5
      CLR_OFF_AND_OT: auto_clear = !i_servo_on || (i_overtravel && !i_zero_clamp); // RULE6
    endcase
    // with no clear the count simply persists through servo off
    want_two = sw_en_q && !sel_sync_q[1]; // RULE9 RULE10
    gear_two_d = gear_two_q;
    if (!sw_en_q) begin
      gear_two_d = 1'b0; // RULE10
    end else if (!sw_seq_q || g.idle) begin
      // sequence 1 waits for an idle residue so no fraction is scaled by a mixed ratio
      gear_two_d = want_two; // RULE11
    end
  end

  assign g.num = gear_two_q ? num_two_q : num_one_q; // RULE9
  assign g.den = den_q;
  assign g.pulse = i_ref_pulse;
  assign g.dir = i_ref_dir;
  assign g.clear = pin_clear || auto_clear;

  // ==========================================================
  // position error counter
  always_comb begin
    fb_step = '0;
    if (i_fb_pulse) begin
      fb_step = i_fb_dir ? -ERR_W'(1) : ERR_W'(1);
    end
    err_d = err_q + ERR_W'(g.delta) - fb_step;
    // feedback moves the other way: a forward count lowers the error
    // clearing wins over counts arriving in the same cycle
    if (pin_clear) begin
      err_d = '0; // RULE1
    end else if (auto_clear) begin
      err_d = '0; // RULE3
    end
    loop_en_d = !pin_clear; // RULE2
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      err_q <= '0;
      loop_en_q <= 1'b0;
      gear_two_q <= 1'b0;
    end else begin
      err_q <= err_d;
      loop_en_q <= loop_en_d;
      gear_two_q <= gear_two_d;
    end
  end

  // ==========================================================
  // register read
  // staged values read back as written; status shows the active copies
  always_comb begin
    rdata_d = '0;
    if (i_rd) begin
      unique case (i_addr)
        OFS_NUM_ONE: rdata_d = DATA_W'(num_one_sh_q);
        OFS_DEN: rdata_d = DATA_W'(den_sh_q);
        OFS_NUM_TWO: rdata_d = DATA_W'(num_two_sh_q);
        OFS_CFG: begin
          rdata_d[CFG_MODE_MSB:CFG_MODE_LSB] = mode_sh_q;
          rdata_d[CFG_SW_EN] = sw_en_sh_q;
          rdata_d[CFG_SW_SEQ] = sw_seq_sh_q;
        end
        OFS_STATUS: begin
          rdata_d[ST_LOOP_EN] = loop_en_q;
          rdata_d[ST_GEAR_TWO] = gear_two_q;
          rdata_d[ST_MODE_MSB:ST_MODE_LSB] = mode_q;
          rdata_d[ST_SW_EN] = sw_en_q;
          rdata_d[ST_SW_SEQ] = sw_seq_q;
        end
        OFS_ERR: rdata_d = DATA_W'(err_q);
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_err_count = err_q;
  assign o_loop_en = loop_en_q;
  assign o_gear_two = gear_two_q;

endmodule

// file: gear_pkg.sv
// ==========================================================
// Overview of operation
// [RULE1] error-clear input low forces the position error counter to zero
// [RULE2] error-clear input low stops the position loop from producing correction
// [RULE3] error pulses are kept while servo off unless the clear mode discards them
// [RULE4] clear mode 0: zero on servo off, keep on over-travel, latched at restart
// [RULE5] clear mode 1: never discard error pulses automatically
// [RULE6] clear mode 2: zero on servo off and over-travel, except during zero clamp
// [RULE7] each reference pulse is scaled by selected numerator over denominator
// [RULE8] host keeps gear ratio within 0.01 to 100 inclusive
// [RULE9] gear-select low uses second numerator, high uses first numerator
// [RULE10] numerator switching only when gear-switch enable allows it, else first
// [RULE11] numerator changeover follows the order chosen by the sequence setting
// [RULE12] numerators and denominator range 1 to 100000, default 1, used after restart
// [RULE13] fractional remainder of scaling is carried so no counts are lost
package gear_pkg;

  // ==========================================================
  // widths
  localparam int GEAR_W = 17;
  localparam int RES_W = 26;
  localparam int DELTA_W = 8;
  localparam int ERR_W = 32;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MAX_SHIFT = 6;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_NUM_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DEN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_NUM_TWO = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ERR = 8'h18;

  // ==========================================================
  // field positions
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_MODE_MSB = 1;
  localparam int CFG_SW_EN = 2;
  localparam int CFG_SW_SEQ = 3;
  localparam int CTRL_RESTART = 0;
  localparam int ST_LOOP_EN = 0;
  localparam int ST_GEAR_TWO = 1;
  localparam int ST_MODE_LSB = 2;
  localparam int ST_MODE_MSB = 3;
  localparam int ST_SW_EN = 4;
  localparam int ST_SW_SEQ = 5;

  // ==========================================================
  // reset values and limits
  localparam logic [GEAR_W-1:0] GEAR_DEFAULT = 17'h00001;
  localparam logic [GEAR_W-1:0] GEAR_MIN = 17'h00001;
  localparam logic [GEAR_W-1:0] GEAR_MAX = 17'h186A0;
  localparam logic [1:0] MODE_DEFAULT = 2'h0;

  typedef enum logic [1:0] {
    CLR_OFF_ONLY,
    CLR_NEVER,
    CLR_OFF_AND_OT
  } clear_mode_t;

endpackage

// file: gear_if.sv
`timescale 1ns/1ns
interface gear_if;
  import gear_pkg::*;
  logic [GEAR_W-1:0] num;
  logic [GEAR_W-1:0] den;
  logic pulse;
  logic dir;
  logic clear;
  logic signed [DELTA_W-1:0] delta;
  logic idle;

  modport ctrl (
    output num,
    output den,
    output pulse,
    output dir,
    output clear,
    input delta,
    input idle
  );
  modport scaler (
    input num,
    input den,
    input pulse,
    input dir,
    input clear,
    output delta,
    output idle
  );
endinterface

// file: gear_scaler.sv
`timescale 1ns/1ns
module gear_scaler
  import gear_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // scaling link
  gear_if.scaler g
);

  logic signed [RES_W-1:0] res_q;
  logic signed [RES_W-1:0] res_d;
  logic signed [DELTA_W-1:0] delta_q;
  logic signed [DELTA_W-1:0] delta_d;
  logic [RES_W-1:0] mag;
  logic [2:0] sh;
  logic signed [RES_W-1:0] step;
  logic signed [RES_W-1:0] num_ext;

  // largest power of two of the denominator that fits; drains big ratios in few cycles
  function automatic logic [2:0] shift_for(input logic [RES_W-1:0] m,
                                           input logic [GEAR_W-1:0] d);
    logic [2:0] s;
    s = 3'h0;
    for (int k = 1; k <= MAX_SHIFT; k++) begin
      if (m >= (RES_W'(d) << k)) begin
        s = 3'(k);
      end
    end
    return s;
  endfunction

  // ==========================================================
  // residue accumulate and drain
  always_comb begin
    mag = res_q[RES_W-1] ? RES_W'(-res_q) : RES_W'(res_q);
    sh = shift_for(mag, g.den);
    step = $signed(RES_W'(g.den) << sh);
    num_ext = $signed(RES_W'(g.num));
    res_d = res_q;
    delta_d = '0;
    if (!res_q[RES_W-1] && (mag >= RES_W'(g.den))) begin
      res_d = res_q - step; // RULE13
      delta_d = $signed(DELTA_W'(1) << sh); // RULE7
    end else if (res_q[RES_W-1]) begin
      res_d = res_q + step; // RULE13
      delta_d = -$signed(DELTA_W'(1) << sh); // RULE7
    end
    if (g.pulse) begin
      res_d = g.dir ? res_d - num_ext : res_d + num_ext; // RULE7
    end
    if (g.clear) begin
      res_d = '0;
      delta_d = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      res_q <= '0;
      delta_q <= '0;
    end else begin
      res_q <= res_d;
      delta_q <= delta_d;
    end
  end

  assign g.delta = delta_q;
  assign g.idle = (res_q == '0) && (delta_q == '0);

endmodule

// file: position_error_clear_and_gear_checker.sv
`timescale 1ns/1ns
module position_error_clear_and_gear_checker
  import gear_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // pins and drive state
  input wire logic i_error_clear_input_n,
  input wire logic i_gear_select_input_n,
  input wire logic i_ref_pulse,
  input wire logic i_fb_pulse,
  input wire logic i_servo_on,
  input wire logic i_overtravel,
  input wire logic i_zero_clamp,
  // results
  input wire logic signed [ERR_W-1:0] o_err_count,
  input wire logic o_loop_en,
  input wire logic o_gear_two
);
  // ==========================================================
  // shadow of the active settings, copied only at restart
  logic [3:0] stg_q, stg_d, act_q, act_d;
  logic auto_clr;
  always_comb begin
    stg_d = stg_q;
    act_d = act_q;
    if (i_wr && i_addr == OFS_CFG) stg_d = i_wdata[3:0];
    if (i_wr && i_addr == OFS_CTRL && i_wdata[CTRL_RESTART]) act_d = stg_q;
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stg_q <= 4'h0;
      act_q <= 4'h0;
    end else begin
      stg_q <= stg_d;
      act_q <= act_d;
    end
  end
  // mode 3 falls back to never clearing
  assign auto_clr = (act_q[1:0] == 2'h0 && !i_servo_on) ||
    (act_q[1:0] == 2'h2 && (!i_servo_on || (i_overtravel && !i_zero_clamp)));

  // ==========================================================
  // properties
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence clr_held;
    !i_error_clear_input_n [*3];
  endsequence
  // eight quiet cycles let the scaler residue drain first
  sequence quiet;
    (!auto_clr && i_error_clear_input_n && !i_ref_pulse && !i_fb_pulse) [*8];
  endsequence
  sequence err_rd;
    i_rd && i_addr == OFS_ERR ##1 $stable(o_err_count);
  endsequence
  a_clear_zeroes_count: assert property (clr_held |=> o_err_count == '0)
    else $error("error count not zero while clear held");
  a_clear_stops_loop: assert property (clr_held |=> !o_loop_en)
    else $error("loop enabled while clear held");
  a_auto_clear: assert property (auto_clr [*3] |=> o_err_count == '0)
    else $error("error count not cleared by clear mode");
  a_keep_count: assert property (quiet |=> $stable(o_err_count))
    else $error("error count changed with nothing to change it");
  a_gear_two_sel: assert property (
    (act_q[2] && !act_q[3] && !i_gear_select_input_n) [*4] |=> o_gear_two)
    else $error("second numerator not selected");
  a_gear_one_sel: assert property (
    (!act_q[2] || (!act_q[3] && i_gear_select_input_n)) [*4] |=> !o_gear_two)
    else $error("second numerator selected wrongly");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == '0)
    else $error("read data outside its cycle");
  a_read_err: assert property (err_rd |-> o_rdata == o_err_count)
    else $error("error count read back wrongly");
endmodule

// file: host_pulse_model.sv
`timescale 1ns/1ns
module host_pulse_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // move request
  input wire logic i_go,
  input wire logic [7:0] i_count,
  input wire logic i_dir,
  // pulse train
  output logic o_pulse,
  output logic o_dir,
  output logic o_busy
);
  // ==========================================================
  // pulses four cycles apart so high ratios drain in between
  logic [7:0] left_q, left_d;
  logic [1:0] gap_q, gap_d;
  logic dir_q, dir_d;
  always_comb begin
    left_d = left_q;
    gap_d = gap_q;
    dir_d = dir_q;
    if (i_go) begin
      left_d = i_count;
      gap_d = 2'h0;
      dir_d = i_dir;
    end else if (left_q != 8'h0) begin
      gap_d = gap_q - 2'h1;
      if (gap_q == 2'h0) left_d = left_q - 8'h1;
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      left_q <= 8'h0;
      gap_q <= 2'h0;
      dir_q <= 1'b0;
    end else begin
      left_q <= left_d;
      gap_q <= gap_d;
      dir_q <= dir_d;
    end
  end
  assign o_busy = left_q != 8'h0;
  assign o_pulse = o_busy && gap_q == 2'h0 && !i_go;
  // idle direction line shows the inverse, never a stale value
  assign o_dir = o_busy ? dir_q : ~dir_q;
endmodule

// file: position_error_clear_and_gear_bench.sv
`timescale 1ns/1ns
module position_error_clear_and_gear_bench
  import gear_pkg::*;
;
  typedef struct {logic [ADDR_W-1:0] a; logic [DATA_W-1:0] e;} note_t;
  logic i_clk = 1'b0, i_rstn = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
  logic [ADDR_W-1:0] i_addr = 8'h00;
  logic [DATA_W-1:0] i_wdata = 32'h0, o_rdata;
  logic clr_n = 1'b1, sel_n = 1'b1, fb = 1'b0, son = 1'b0, ot = 1'b0, zc = 1'b0, fbd = 1'b0;
  logic go = 1'b0, h_dir = 1'b0, busy, ref_p, ref_d, o_loop_en, o_gear_two;
  logic [7:0] cnt = 8'h0;
  logic signed [ERR_W-1:0] o_err_count;
  note_t notes[$];
  note_t nt;
  int err_total = 0, tests_run = 0, seed = 37503, n, m, e, w;

  position_error_clear_and_gear dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_error_clear_input_n(clr_n), .i_gear_select_input_n(sel_n), .i_ref_pulse(ref_p),
    .i_ref_dir(ref_d), .i_fb_pulse(fb), .i_fb_dir(fbd), .i_servo_on(son),
    .i_overtravel(ot), .i_zero_clamp(zc), .o_err_count(o_err_count),
    .o_loop_en(o_loop_en), .o_gear_two(o_gear_two));
  host_pulse_model host_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_go(go), .i_count(cnt),
    .i_dir(h_dir), .o_pulse(ref_p), .o_dir(ref_d), .o_busy(busy));

  // ==========================================================
  // tasks
  task automatic wrap_up();
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_total++;
      $display("wrong value read at %h expected %h seen %h", a, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    notes.push_back('{a, x});
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask
  task automatic send(input logic [7:0] c, input logic d);
    int k;
    @(posedge i_clk);
    go <= 1'b1;
    cnt <= c;
    h_dir <= d;
    @(posedge i_clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (busy !== 1'b0 && k < 400);
    if (busy !== 1'b0) begin
      err_total++;
      wrap_up();
    end else repeat (10) @(posedge i_clk);
  endtask

  // ==========================================================
  // clock and result watcher
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) rd_d <= i_rd;
  always @(negedge i_clk) begin
    if (rd_d === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      chk(nt.a, o_rdata, nt.e);
    end
  end
  initial begin
    #3000000;
    err_total++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    rd(OFS_NUM_ONE, 32'h1);
    rd(OFS_DEN, 32'h1);
    rd(OFS_NUM_TWO, 32'h1);
    rd(OFS_CFG, 32'h0);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_CTRL, 32'h0);
    rd(8'h40, 32'h0);
    son <= 1'b1;
    wr(OFS_NUM_ONE, 32'h3);
    wr(OFS_DEN, 32'h2);
    wr(OFS_CTRL, 32'h1);
    n = 1 + ($unsigned($random(seed)) % 16);
    send(n[7:0], 1'b0);
    rd(OFS_ERR, 32'((n * 3) / 2));
    send(n[7:0], 1'b0);
    rd(OFS_ERR, 32'(n * 3));
    repeat (5) @(posedge i_clk) fb <= 1'b1;
    @(posedge i_clk) fbd <= 1'b1;
    @(posedge i_clk) fb <= 1'b0;
    repeat (6) @(posedge i_clk);
    rd(OFS_ERR, 32'(n * 3 - 4));
    clr_n <= 1'b0;
    send(8'h3, 1'b0);
    rd(OFS_ERR, 32'h0);
    rd(OFS_STATUS, 32'h0);
    clr_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd(OFS_ERR, 32'h0);
    rd(OFS_STATUS, 32'h1);
    for (m = 0; m < 4; m++) begin
      wr(OFS_CFG, 32'(m));
      rd(OFS_STATUS, 32'h1 | 32'((m == 0 ? 0 : m - 1) << 2));
      wr(OFS_CTRL, 32'h1);
      for (e = 0; e < 3; e++) begin
        send(8'h4, 1'b0);
        son <= (e != 0);
        ot <= (e != 0);
        zc <= (e == 2);
        repeat (8) @(posedge i_clk);
        w = ((e == 0 && m % 2 == 0) || (e == 1 && m == 2)) ? 0 : 6;
        rd(OFS_ERR, 32'(w));
        son <= 1'b1;
        ot <= 1'b0;
        zc <= 1'b0;
        clr_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        clr_n <= 1'b1;
        repeat (5) @(posedge i_clk);
      end
    end
    wr(OFS_NUM_TWO, 32'h2);
    wr(OFS_CFG, 32'h4);
    wr(OFS_CTRL, 32'h1);
    sel_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    rd(OFS_STATUS, 32'h13);
    send(8'h4, 1'b0);
    rd(OFS_ERR, 32'h4);
    wr(OFS_CFG, 32'hC);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_STATUS, 32'h33);
    sel_n <= 1'b1;
    repeat (6) @(posedge i_clk);
    rd(OFS_STATUS, 32'h31);
    send(8'h2, 1'b1);
    rd(OFS_ERR, 32'h1);
    wr(OFS_CFG, 32'h0);
    wr(OFS_CTRL, 32'h1);
    sel_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    rd(OFS_STATUS, 32'h1);
    wr(OFS_DEN, 32'h0);
    rd(OFS_DEN, 32'h0);
    wr(OFS_CTRL, 32'h1);
    send(8'h2, 1'b0);
    rd(OFS_ERR, 32'h7);
    repeat (3) @(posedge i_clk);
    wrap_up();
  end
endmodule

bind position_error_clear_and_gear position_error_clear_and_gear_checker chk_u (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_error_clear_input_n(i_error_clear_input_n),
  .i_gear_select_input_n(i_gear_select_input_n), .i_ref_pulse(i_ref_pulse),
  .i_fb_pulse(i_fb_pulse), .i_servo_on(i_servo_on), .i_overtravel(i_overtravel),
  .i_zero_clamp(i_zero_clamp), .o_err_count(o_err_count), .o_loop_en(o_loop_en),
  .o_gear_two(o_gear_two));
